// >>> shared/dsc_pkg.sv
// Purpose: shared constants and carriers for the instruction decoder
// Assumes: opcode in the top byte of each 24-bit program word
// Notes: opcode values and operand bit positions are local encodings
package dsc_pkg;
  localparam int INSTR_W = 24;
  localparam int OPC_LSB = 16;
  // opcodes, one byte each
  localparam logic [7:0] OPC_NOP = 8'h00;
  localparam logic [7:0] OPC_CALL_LIT = 8'h02;
  localparam logic [7:0] OPC_GOTO_LIT = 8'h04;
  localparam logic [7:0] OPC_DO = 8'h08;
  localparam logic [7:0] OPC_BRA_COMP = 8'h01;
  localparam logic [7:0] OPC_CALL_IND = 8'h03;
  localparam logic [7:0] OPC_GOTO_IND = 8'h05;
  localparam logic [7:0] OPC_RETURN = 8'h06;
  localparam logic [7:0] OPC_RET_INT = 8'h07;
  localparam logic [7:0] OPC_TABLE = 8'h0A;
  localparam logic [7:0] OPC_SKIP = 8'h0C;
  localparam logic [7:0] OPC_MOVD = 8'h0D;
  localparam logic [7:0] OPC_BRA_COND = 8'h30;
  localparam logic [7:0] OPC_BRA = 8'h37;
  // opcode groups (upper nibble) and dsp group (upper five bits)
  localparam logic [3:0] GRP_FILE = 4'h2;
  localparam logic [3:0] GRP_LIT = 4'h4;
  localparam logic [3:0] GRP_BIT = 4'hA;
  localparam logic [4:0] GRP_DSP = 5'h18;
  localparam int DSP_SQ_BIT = 2;
  // operand field positions
  localparam int BYTE_BIT = 15;
  localparam int DEST_BIT = 14;
  localparam int F_LSB = 0;
  localparam int BIT_SELECT_FIELD_LSB = 12;
  localparam int TEN_BIT_LITERAL_LSB = 4;
  localparam int WN_LSB = 0;
  localparam int ACC_BIT = 15;
  localparam int PAIR_LSB = 12;
  localparam int WX_LSB = 8;
  localparam int WXD_LSB = 6;
  localparam int WY_LSB = 2;
  localparam int WYD_LSB = 0;
  localparam int TGT_HI_LSB = 0;
  // limits
  localparam logic [12:0] F_MAX = 13'h1FFF;
  localparam logic [12:0] DBG_RAM_BYTES = 13'h0050;
  localparam logic [9:0] BYTE_LIT_MAX = 10'h0FF;
  // extra instruction cycles beyond the first
  localparam logic [1:0] XC_NONE = 2'h0;
  localparam logic [1:0] XC_ONE = 2'h1;
  localparam logic [1:0] XC_TWO = 2'h2;
  // registers and prefetch codes
  localparam logic [3:0] REG_W0 = 4'h0;
  localparam logic [3:0] REG_W4 = 4'h4;
  localparam logic [3:0] REG_W8 = 4'h8;
  localparam logic [3:0] REG_W9 = 4'h9;
  localparam logic [3:0] REG_W10 = 4'hA;
  localparam logic [3:0] REG_W11 = 4'hB;
  localparam logic [3:0] REG_W12 = 4'hC;
  localparam logic [3:0] REG_W13 = 4'hD;
  localparam logic [3:0] PF_IDX = 4'hE;
  localparam logic [3:0] PF_NONE = 4'hF;
  localparam logic [3:0] PF_PER_REG = 4'h7;
  localparam logic [1:0] AWB_NONE = 2'h0;
  localparam logic [1:0] AWB_DIRECT = 2'h1;
  localparam logic [1:0] AWB_POSTINC = 2'h2;
  localparam logic [1:0] DBG_PAIR1 = 2'h3;
  localparam logic [1:0] DBG_PAIR2 = 2'h2;
  localparam logic [1:0] DBG_PAIR3 = 2'h1;
  typedef struct packed {
    logic en;
    logic [3:0] areg;
    logic idx;
    logic signed [3:0] mod;
  } dsc_pf_t;
  typedef struct packed {
    logic acc_b;
    logic [3:0] mul_a;
    logic [3:0] mul_b;
    dsc_pf_t x_pf;
    logic [3:0] x_dst;
    dsc_pf_t y_pf;
    logic [3:0] y_dst;
    logic awb_en;
    logic awb_postinc;
    logic legal;
  } dsc_dsp_t;
  typedef struct packed {
    logic [12:0] file_addr;
    logic [3:0] dest_reg;
    logic byte_mode;
    logic [3:0] bit_sel;
    logic [9:0] ten_bit_literal;
    logic [3:0] wn;
    logic lit_err;
    logic [22:0] target;
    logic target_err;
  } dsc_gen_t;
endpackage

// >>> hdl/dsc_dsp_dec.sv
// Purpose: operand decode for multiply class dsp words
// Assumes: opcode bits 1:0 carry the write-back choice
// Notes: purely combinational; the top registers the result
`timescale 1ns/100ps
module dsc_dsp_dec (
  // word in
  input wire logic [23:0] i_word,
  // decoded operands
  output dsc_pkg::dsc_dsp_t o_dsp
);
  function automatic dsc_pkg::dsc_pf_t pf_dec(input logic [3:0] code, input logic [3:0] ra,
                                               input logic [3:0] rb);
    dsc_pkg::dsc_pf_t p;
    logic [3:0] sub;
    p.en = (code != dsc_pkg::PF_NONE);
    p.idx = (code == dsc_pkg::PF_IDX);
    p.areg = (code < dsc_pkg::PF_PER_REG) ? ra : rb;
    sub = (code < dsc_pkg::PF_PER_REG) ? code : code - dsc_pkg::PF_PER_REG;
    unique case (sub)
      4'h1: p.mod = 4'sh2;
      4'h2: p.mod = 4'sh4;
      4'h3: p.mod = 4'sh6;
      4'h4: p.mod = -4'sh2;
      4'h5: p.mod = -4'sh4;
      4'h6: p.mod = -4'sh6;
      default: p.mod = 4'sh0;
    endcase
    if (!p.en || p.idx) p.mod = 4'sh0;
    return p;
  endfunction
  wire logic square = i_word[dsc_pkg::OPC_LSB + dsc_pkg::DSP_SQ_BIT];
  wire logic [1:0] acc_writeback_dest = i_word[dsc_pkg::OPC_LSB +: 2];
  wire logic [2:0] pair = i_word[dsc_pkg::PAIR_LSB +: 3];
  logic [3:0] ma;
  logic [3:0] mb;
  always_comb begin
    ma = dsc_pkg::REG_W4;
    mb = dsc_pkg::REG_W4;
    if (square) begin
      ma = dsc_pkg::REG_W4 + {2'h0, pair[1:0]};
      mb = ma;
    end else begin
      unique case (pair)
        3'h0: begin ma = 4'h4; mb = 4'h5; end
        3'h1: begin ma = 4'h4; mb = 4'h6; end
        3'h2: begin ma = 4'h4; mb = 4'h7; end
        3'h3: begin ma = 4'h5; mb = 4'h6; end
        3'h4: begin ma = 4'h5; mb = 4'h7; end
        3'h5: begin ma = 4'h6; mb = 4'h7; end
        default: begin ma = 4'h4; mb = 4'h4; end
      endcase
    end
  end
  assign o_dsp.acc_b = i_word[dsc_pkg::ACC_BIT];
  assign o_dsp.mul_a = ma;
  assign o_dsp.mul_b = mb;
  assign o_dsp.x_pf = pf_dec(i_word[dsc_pkg::WX_LSB +: 4], dsc_pkg::REG_W8, dsc_pkg::REG_W9);
  assign o_dsp.y_pf = pf_dec(i_word[dsc_pkg::WY_LSB +: 4], dsc_pkg::REG_W10, dsc_pkg::REG_W11);
  assign o_dsp.x_dst = dsc_pkg::REG_W4 + {2'h0, i_word[dsc_pkg::WXD_LSB +: 2]};
  assign o_dsp.y_dst = dsc_pkg::REG_W4 + {2'h0, i_word[dsc_pkg::WYD_LSB +: 2]};
  assign o_dsp.awb_en = (acc_writeback_dest == dsc_pkg::AWB_DIRECT) || (acc_writeback_dest == dsc_pkg::AWB_POSTINC);
  assign o_dsp.awb_postinc = (acc_writeback_dest == dsc_pkg::AWB_POSTINC);
  assign o_dsp.legal = (square ? !pair[2] : (pair < 3'h6)) && (acc_writeback_dest != 2'h3);
endmodule

// >>> hdl/dsc_gen_dec.sv
// Purpose: file, bit, literal and target operand decode
// Assumes: i_word1 holds the first word of a two-word target
// Notes: combinational; range faults are flagged, never corrected
`timescale 1ns/100ps
module dsc_gen_dec (
  // words in
  input wire logic [23:0] i_word1,
  input wire logic [23:0] i_word2,
  // decoded operands
  output dsc_pkg::dsc_gen_t o_gen
);
  wire logic byte_mode = i_word2[dsc_pkg::BYTE_BIT];
  wire logic [9:0] lit = i_word2[dsc_pkg::TEN_BIT_LITERAL_LSB +: 10];
  wire logic [22:0] tgt = {i_word2[dsc_pkg::TGT_HI_LSB +: 7], i_word1[15:0]};
  assign o_gen.file_addr = i_word2[dsc_pkg::F_LSB +: 13] & dsc_pkg::F_MAX;
  assign o_gen.dest_reg = i_word2[dsc_pkg::DEST_BIT] ? dsc_pkg::REG_W0 : 4'hF;
  assign o_gen.byte_mode = byte_mode;
  assign o_gen.bit_sel = i_word2[dsc_pkg::BIT_SELECT_FIELD_LSB +: 4];
  assign o_gen.ten_bit_literal = lit;
  assign o_gen.wn = i_word2[dsc_pkg::WN_LSB +: 4];
  assign o_gen.lit_err = byte_mode && (lit > dsc_pkg::BYTE_LIT_MAX);
  assign o_gen.target = tgt;
  assign o_gen.target_err = tgt[0];
endmodule

// >>> hdl/dsc_instr_decode.sv
// Purpose: fetch sequencing, cycle timing and operand decode of the core
// Assumes: one instruction cycle per clock; i_cond_true valid with the word
// Notes: decoded outputs are registered and valid while o_issue is high
// Summary of operation
// - each single word is 24 bits; top 8 bits select the instruction
// - only three instructions span two words, 48 bits in all
// - second word of a two-word instruction has its top 8 bits zero
// - a second word executed alone behaves as a no-operation
// - one cycle normally; true condition or pc change adds a nop cycle
// - branches, indirect call/goto, table ops, returns take two or three cycles
// - taken skip costs two cycles, three when the skipped instruction is two words
// - double moves and every two-word instruction take two cycles
// - debug enabled reserves the lowest 80 ram bytes and two pins
// - debug uses one of three clock/data pairs; the debugger drives clock
// - file ops name an address and a destination of itself or w0
// - file address operand covers 0x0000 to 0x1FFF
// - bit select is a 4-bit field naming bits 0 to 15
// - ten-bit literal limited to 255 in byte mode, 1023 in word mode
// - 23-bit program target literal must have a zero lsb
// - square ops accept only w4*w4, w5*w5, w6*w6, w7*w7
// - multiply ops accept only the six distinct pairs of w4 to w7
// - x prefetch: w8 or w9 plain or +-2,4,6, w9+w12, or none
// - y prefetch: w10 or w11 plain or +-2,4,6, w11+w12, or none
// - x and y prefetch destinations are w4 to w7
// - accumulator write-back goes to w13 or [w13] post-incremented by 2
// - dsp ops name exactly one accumulator, a or b
`timescale 1ns/100ps
module dsc_instr_decode (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // program memory side
  input wire logic i_fetch_valid,
  input wire logic [23:0] i_fetch_word,
  output logic o_fetch_ready,
  // condition result from the datapath
  input wire logic i_cond_true,
  // debug configuration
  input wire logic i_debug_en,
  input wire logic [1:0] i_debug_pair_sel,
  // datapath side
  output logic o_issue,
  output logic [7:0] o_opcode,
  output logic o_is_nop,
  output logic o_bubble,
  output dsc_pkg::dsc_dsp_t o_dsp,
  output logic o_dsp_op,
  output dsc_pkg::dsc_gen_t o_gen,
  output logic o_word2_err,
  // debug resources
  output logic o_ram_reserved,
  output logic [2:0] o_debug_pin_sel,
  output logic [2:0] o_debug_clock_pin_oe
);
  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_WORD2 = 2'b01,
    ST_STALL = 2'b11,
    ST_SKIP = 2'b10
  } dsc_state_t;

  function automatic logic is_dword(input logic [7:0] opc);
    return (opc == dsc_pkg::OPC_CALL_LIT) || (opc == dsc_pkg::OPC_GOTO_LIT) || (opc == dsc_pkg::OPC_DO);
  endfunction

  function automatic logic [1:0] extra_cycles(input logic [7:0] opc, input logic cond);
    logic [1:0] xc;
    xc = dsc_pkg::XC_NONE;
    unique case (opc)
      dsc_pkg::OPC_BRA, dsc_pkg::OPC_BRA_COMP,
      dsc_pkg::OPC_CALL_IND, dsc_pkg::OPC_GOTO_IND,
      dsc_pkg::OPC_TABLE, dsc_pkg::OPC_MOVD: xc = dsc_pkg::XC_ONE;
      dsc_pkg::OPC_RETURN, dsc_pkg::OPC_RET_INT: xc = dsc_pkg::XC_TWO;
      dsc_pkg::OPC_BRA_COND: xc = cond ? dsc_pkg::XC_ONE : dsc_pkg::XC_NONE;
      default: xc = dsc_pkg::XC_NONE;
    endcase
    return xc;
  endfunction

  dsc_state_t state;
  dsc_state_t next_state;
  logic [1:0] stall_cnt;
  logic [1:0] next_stall_cnt;
  logic discard;
  logic next_discard;
  logic [23:0] first_word;
  logic ready;

  wire logic [7:0] opc = i_fetch_word[dsc_pkg::OPC_LSB +: 8];
  wire logic accept = i_fetch_valid && ready;
  wire logic in_exec = (state == ST_EXEC);
  wire logic in_word2 = (state == ST_WORD2);
  wire logic in_skip = (state == ST_SKIP);
  wire logic in_stall = (state == ST_STALL);
  wire logic dw_now = is_dword(opc);
  wire logic skip_taken = (opc == dsc_pkg::OPC_SKIP) && i_cond_true;
  wire logic [1:0] xc_now = extra_cycles(opc, i_cond_true);
  wire logic is_dsp = (opc[7:3] == dsc_pkg::GRP_DSP);
  wire logic is_file = (opc[7:4] == dsc_pkg::GRP_FILE);
  // a single-word issue, or the completing second word
  wire logic issue_single = accept && in_exec && !dw_now;
  wire logic issue_double = accept && in_word2 && !discard;
  wire logic bubble_now = in_stall || (accept && in_skip) || (accept && in_word2 && discard);
  wire logic [23:0] word1_sel = issue_double ? first_word : i_fetch_word;
  wire logic hi_nonzero = (opc != 8'h00);

  dsc_pkg::dsc_dsp_t dsp_dec;
  dsc_pkg::dsc_gen_t gen_dec;

  dsc_dsp_dec u_dsp_dec (
    .i_word(i_fetch_word),
    .o_dsp(dsp_dec)
  );

  dsc_gen_dec u_gen_dec (
    .i_word1(word1_sel),
    .i_word2(i_fetch_word),
    .o_gen(gen_dec)
  );

  always_comb begin
    next_state = state;
    next_stall_cnt = stall_cnt;
    next_discard = discard;
    unique case (state)
      ST_EXEC: begin
        if (accept) begin
          if (dw_now) begin
            next_state = ST_WORD2;
            next_discard = 1'b0;
          end else if (skip_taken) begin
            next_state = ST_SKIP;
          end else if (xc_now != dsc_pkg::XC_NONE) begin
            next_state = ST_STALL;
            next_stall_cnt = xc_now;
          end
        end
      end
      ST_WORD2: begin
        // second cycle of a two-word op
        if (accept) next_state = ST_EXEC;
      end
      ST_SKIP: begin
        if (accept) begin
          next_state = dw_now ? ST_WORD2 : ST_EXEC;
          next_discard = dw_now;
        end
      end
      ST_STALL: begin
        next_stall_cnt = stall_cnt - 2'h1;
        if (stall_cnt == 2'h1) next_state = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_EXEC;
      stall_cnt <= 2'h0;
      discard <= 1'b0;
      ready <= 1'b1;
      first_word <= 24'h000000;
    end else begin
      state <= next_state;
      stall_cnt <= next_stall_cnt;
      discard <= next_discard;
      // stalls hold off the program memory
      ready <= (next_state != ST_STALL);
      if (accept && in_exec && dw_now) first_word <= i_fetch_word;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_issue <= 1'b0;
      o_opcode <= 8'h00;
      o_is_nop <= 1'b0;
      o_bubble <= 1'b0;
      o_dsp_op <= 1'b0;
      o_word2_err <= 1'b0;
    end else begin
      o_issue <= issue_single || issue_double;
      o_opcode <= issue_double ? first_word[dsc_pkg::OPC_LSB +: 8] : opc;
      // lone second word is a nop
      o_is_nop <= issue_single && (opc == dsc_pkg::OPC_NOP);
      o_bubble <= bubble_now;
      // accumulator select travels with dsp ops
      o_dsp_op <= issue_single && is_dsp;
      // second word must carry a zero opcode
      o_word2_err <= accept && in_word2 && hi_nonzero;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dsp <= '0;
      o_gen <= '0;
    end else if (issue_single || issue_double) begin
      o_dsp <= dsp_dec;
      o_gen <= gen_dec;
    end
  end

  // low ram held for debug
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ram_reserved <= 1'b0;
    end else begin
      o_ram_reserved <= i_debug_en && issue_single && is_file && (gen_dec.file_addr < dsc_pkg::DBG_RAM_BYTES);
    end
  end

  // one pair chosen; clock is always an input here
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_debug_pin_sel <= 3'h0;
      o_debug_clock_pin_oe <= 3'h0;
    end else begin
      o_debug_pin_sel <= !i_debug_en ? 3'h0 :
                         (i_debug_pair_sel == dsc_pkg::DBG_PAIR1) ? 3'h1 :
                         (i_debug_pair_sel == dsc_pkg::DBG_PAIR2) ? 3'h2 :
                         (i_debug_pair_sel == dsc_pkg::DBG_PAIR3) ? 3'h4 : 3'h0;
      o_debug_clock_pin_oe <= 3'h0;
    end
  end

  assign o_fetch_ready = ready;

  // checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  a_dword_two_cyc: assert property (
    accept && in_exec && dw_now ##1 (i_fetch_valid && !hi_nonzero) |=> o_issue && !o_bubble)
    else $error("two-word op did not issue in its second cycle");

  a_dword_state: assert property (
    accept && in_exec && dw_now |=> in_word2 && !o_issue)
    else $error("two-word op first word mishandled");

  a_word2_zero: assert property (
    accept && in_word2 && hi_nonzero |=> o_word2_err)
    else $error("nonzero second word opcode not flagged");

  a_lone_nop: assert property (
    accept && in_exec && opc == dsc_pkg::OPC_NOP |=> o_issue && o_is_nop && !o_ram_reserved)
    else $error("lone second word not executed as nop");

  a_cond_taken: assert property (
    accept && in_exec && opc == dsc_pkg::OPC_BRA_COND && i_cond_true |=> o_issue ##1 o_bubble ##1 !o_bubble)
    else $error("taken branch not two cycles");

  a_cond_fall: assert property (
    accept && in_exec && opc == dsc_pkg::OPC_BRA_COND && !i_cond_true |=> ##1 !o_bubble)
    else $error("untaken branch added a cycle");

  a_return_three: assert property (
    accept && in_exec && (opc == dsc_pkg::OPC_RETURN || opc == dsc_pkg::OPC_RET_INT)
    |=> !o_fetch_ready[*2] ##1 o_fetch_ready)
    else $error("return not three cycles");

  a_branch_two: assert property (
    accept && in_exec && opc == dsc_pkg::OPC_BRA |=> ##1 o_bubble ##1 !o_bubble)
    else $error("branch not two cycles");

  a_skip_single: assert property (
    accept && in_exec && skip_taken ##1 (i_fetch_valid && !dw_now) |=> o_bubble && in_exec)
    else $error("skip of one word wrong");

  a_skip_double: assert property (
    accept && in_exec && skip_taken ##1 (i_fetch_valid && dw_now) |=> in_word2 && discard && o_bubble)
    else $error("skip of two words wrong");

  a_byte_lit: assert property (
    issue_single && i_fetch_word[dsc_pkg::BYTE_BIT] &&
    (i_fetch_word[dsc_pkg::TEN_BIT_LITERAL_LSB +: 10] > dsc_pkg::BYTE_LIT_MAX) |=> o_gen.lit_err)
    else $error("byte literal range fault missed");

  a_target_lsb: assert property (
    issue_double |=> o_issue && (o_gen.target_err == $past(first_word[0])))
    else $error("odd target not flagged");

  a_pair_range: assert property (
    o_dsp_op && o_dsp.legal |-> o_dsp.mul_a >= dsc_pkg::REG_W4 && o_dsp.mul_b <= 4'h7)
    else $error("multiply pair outside w4 to w7");

  a_debug_ram: assert property (
    o_ram_reserved |-> $past(i_debug_en) && o_gen.file_addr < dsc_pkg::DBG_RAM_BYTES)
    else $error("reserve flagged outside debug window");

  a_debug_pair: assert property (
    $onehot0(o_debug_pin_sel) && o_debug_clock_pin_oe == 3'h0)
    else $error("debug pair selection not exclusive");

  c_dword_issue: cover property (accept && in_exec && dw_now ##1 accept ##1 o_issue);
  c_skip_dword: cover property (accept && in_skip && dw_now);
  c_return: cover property (accept && in_exec && opc == dsc_pkg::OPC_RET_INT);
  c_debug_hit: cover property (o_ram_reserved);
endmodule

// >>> tb/dsc_prog_mem.sv
// Purpose: program memory stand-in that feeds words and condition bits
// Assumes: the bench fills the queue only while stalled
// Notes: idle word flips every cycle, so a stale word never passes for a held one
`timescale 1ns/100ps
module dsc_prog_mem (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // control from bench and decoder
  input wire logic i_stall,
  input wire logic i_ready,
  // fetch side
  output logic o_valid,
  output logic [23:0] o_word,
  output logic o_cond
);
  logic [24:0] q[$];
  // whole 24-bit words, held until taken
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_valid <= 1'b0;
      o_word <= 24'h000000;
      o_cond <= 1'b0;
    end else begin
      if (o_valid && i_ready && q.size() > 0) begin
        void'(q.pop_front());
      end
      if (q.size() > 0 && !i_stall) begin
        o_valid <= 1'b1;
        {o_cond, o_word} <= q[0];
      end else begin
        o_valid <= 1'b0;
        o_word <= ~o_word;
        o_cond <= ~o_cond;
      end
    end
  end
endmodule

// >>> tb/tb_dsc_instr_decode.sv
// Purpose: self-checking bench for the instruction decoder
// Assumes: one issue record per o_issue pulse, gaps measured in cycles
// Notes: each scenario but t_debug loads words while stalled, then runs them
`timescale 1ns/100ps
module tb_dsc_instr_decode;
  logic clk, rst_n, stall, dbg_en, ready, valid, cond, issue, nop, bub, dop, w2e, ram;
  logic [1:0] psel;
  logic [23:0] word;
  logic [7:0] opc;
  logic [2:0] pin, oe;
  dsc_pkg::dsc_dsp_t dsp;
  dsc_pkg::dsc_gen_t gen;
  int n_fail, compares, cyc, nb, nw2;
  int ic[$];
  logic [7:0] iop[$];
  logic [2:0] ifl[$];
  dsc_pkg::dsc_gen_t ig[$];
  dsc_pkg::dsc_dsp_t id[$];
  dsc_prog_mem mem (.i_sys_clk(clk), .i_reset_n(rst_n), .i_stall(stall), .i_ready(ready),
    .o_valid(valid), .o_word(word), .o_cond(cond));
  dsc_instr_decode dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_fetch_valid(valid),
    .i_fetch_word(word), .o_fetch_ready(ready), .i_cond_true(cond), .i_debug_en(dbg_en),
    .i_debug_pair_sel(psel), .o_issue(issue), .o_opcode(opc), .o_is_nop(nop),
    .o_bubble(bub), .o_dsp(dsp), .o_dsp_op(dop), .o_gen(gen), .o_word2_err(w2e),
    .o_ram_reserved(ram), .o_debug_pin_sel(pin), .o_debug_clock_pin_oe(oe));
  always @(posedge clk) begin
    cyc++;
    if (bub === 1'b1) nb++;
    if (w2e === 1'b1) nw2++;
    if (issue === 1'b1) begin
      ic.push_back(cyc);
      iop.push_back(opc);
      ig.push_back(gen);
      id.push_back(dsp);
      ifl.push_back({dop, nop, ram});
    end
  end
  task automatic chk(logic [63:0] g, logic [63:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic ld(logic c, logic [23:0] w);
    mem.q.push_back({c, w});
  endtask
  // runs the loaded words until n issues show, then stalls again
  task automatic run(int n);
    ic.delete(); iop.delete(); ig.delete(); id.delete(); ifl.delete();
    nb = 0;
    nw2 = 0;
    @(posedge clk);
    stall <= 1'b0;
    for (int k = 0; k < 300 && ic.size() < n; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    stall <= 1'b1;
    @(posedge clk);
    chk(ic.size(), n);
  endtask
  task automatic t_timing;
    logic [7:0] ops[10] = '{dsc_pkg::OPC_BRA, dsc_pkg::OPC_BRA_COMP, dsc_pkg::OPC_CALL_IND,
      dsc_pkg::OPC_GOTO_IND, dsc_pkg::OPC_TABLE, dsc_pkg::OPC_MOVD, dsc_pkg::OPC_RETURN,
      dsc_pkg::OPC_RET_INT, dsc_pkg::OPC_BRA_COND, dsc_pkg::OPC_BRA_COND};
    int ex[10] = '{1, 1, 1, 1, 1, 1, 2, 2, 1, 0};
    for (int i = 0; i < 10; i++) begin
      ld(i == 8, {ops[i], 16'h0000});
      ld(1'b0, 24'h000000);
      run(2);
      chk(ic[1] - ic[0], 1 + ex[i]);
      chk(nb, ex[i]);
      chk(iop[0], ops[i]);
    end
  endtask
  task automatic t_two_word;
    logic [7:0] ops[3] = '{dsc_pkg::OPC_CALL_LIT, dsc_pkg::OPC_GOTO_LIT, dsc_pkg::OPC_DO};
    for (int i = 0; i < 4; i++) begin
      ld(1'b0, 24'h000000);
      ld(1'b0, {ops[i % 3], 15'h091A, i == 3});
      ld(1'b0, {7'h00, i == 3, 16'h0056});
      ld(1'b0, 24'h000000);
      run(3);
      chk(iop[1], ops[i % 3]);
      chk(ic[1] - ic[0], 2);
      chk(ic[2] - ic[1], 1);
      chk(ig[1].target, {7'h56, 15'h091A, i == 3});
      chk(ig[1].target_err, i == 3);
      chk(nw2, i == 3);
    end
    ld(1'b0, 24'h000056);
    run(1);
    chk(ifl[0][1], 1'b1);
  endtask
  task automatic t_skip;
    for (int i = 0; i < 3; i++) begin
      ld(i != 2, {dsc_pkg::OPC_SKIP, 16'h0000});
      ld(1'b0, {i == 1 ? dsc_pkg::OPC_GOTO_LIT : 8'h20, 16'h0010});
      if (i == 1) ld(1'b0, 24'h000000);
      ld(1'b0, 24'h000000);
      run(i == 2 ? 3 : 2);
      chk(ic[1] - ic[0], i == 0 ? 2 : (i == 1 ? 3 : 1));
      chk(nb, i == 2 ? 0 : i + 1);
    end
  endtask
  task automatic t_fields;
    dbg_en <= 1'b1;
    ld(1'b0, {8'h20, 3'b010, 13'h1FFF});
    ld(1'b0, {8'h20, 3'b000, 13'h004F});
    ld(1'b0, {8'h20, 3'b000, 13'h0050});
    ld(1'b0, {8'h40, 2'b10, 10'h100, 4'h3});
    ld(1'b0, {8'h40, 2'b00, 10'h3FF, 4'h5});
    ld(1'b0, {8'hA0, 4'hF, 12'h000});
    run(6);
    chk(ig[0].file_addr, 13'h1FFF);
    chk(ig[0].dest_reg, dsc_pkg::REG_W0);
    chk(ig[1].dest_reg, 4'hF);
    chk({ifl[0][0], ifl[1][0], ifl[2][0]}, 3'b010);
    chk(ifl[0][2], 1'b0);
    chk({ig[3].ten_bit_literal, ig[3].wn, ig[3].lit_err}, {10'h100, 4'h3, 1'b1});
    chk({ig[4].ten_bit_literal, ig[4].lit_err}, {10'h3FF, 1'b0});
    chk(ig[5].bit_sel, 4'hF);
    dbg_en <= 1'b0;
  endtask
  task automatic t_dsp;
    logic [3:0] ma[6] = '{4, 4, 4, 5, 5, 6};
    logic [3:0] mb[6] = '{5, 6, 7, 6, 7, 7};
    logic [3:0] md[7] = '{0, 2, 4, 6, 4'hE, 4'hC, 4'hA};
    dsc_pkg::dsc_dsp_t d;
    for (int p = 0; p < 12; p++) begin
      ld(1'b0, {p < 7 ? 8'hC0 : 8'hC4, p < 7, 3'(p < 7 ? p : p - 7), 12'hF3C});
      run(1);
      d = id[0];
      chk({d.legal, d.acc_b, ifl[0][2]}, {p != 6 && p != 11, p < 7, 1'b1});
      if (p < 6) chk({d.mul_a, d.mul_b}, {ma[p], mb[p]});
      if (p > 6 && p < 11) chk({d.mul_a, d.mul_b}, {4'(p - 3), 4'(p - 3)});
    end
    for (int a = 0; a < 4; a++) begin
      ld(1'b0, {6'h30, 2'(a), 16'h0F3C});
      run(1);
      chk({id[0].awb_en, id[0].awb_postinc, id[0].legal}, {a == 1 || a == 2, a == 2, a != 3});
    end
    for (int c = 0; c < 16; c++) begin
      ld(1'b0, {8'hC0, 4'h0, 4'(c), 2'(c), 4'(c), 2'(c)});
      run(1);
      d = id[0];
      chk({d.x_pf.en, d.y_pf.en, d.x_dst, d.y_dst}, {c != 15, c != 15, 4'(4 + c % 4), 4'(4 + c % 4)});
      if (c < 15) chk({d.x_pf.areg, d.y_pf.areg, d.x_pf.idx}, {c < 7 ? 8'h8A : 8'h9B, c == 14});
      if (c < 14) chk({d.x_pf.mod, d.y_pf.mod}, {md[c % 7], md[c % 7]});
    end
  endtask
  task automatic t_debug;
    logic [2:0] ex[4] = '{3'b000, 3'b100, 3'b010, 3'b001};
    for (int p = 0; p < 5; p++) begin
      @(posedge clk);
      dbg_en <= p < 4;
      psel <= p < 4 ? 2'(p) : 2'h3;
      repeat (2) @(posedge clk);
      chk({pin, oe}, {p < 4 ? ex[p] : 3'b000, 3'b000});
    end
    dbg_en <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // generous bound: all scenarios need well under two thousand cycles
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
  initial begin
    {rst_n, stall, dbg_en, psel} = 5'b01000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_timing();
    t_two_word();
    t_skip();
    t_fields();
    t_dsp();
    t_debug();
    end_of_test();
  end
endmodule
